// *** verilog/dtg_pkg.sv ***
// Constants, field layout and state type of the keypad tone generator.
// How it works
// - Writing run bit 1 starts the bursts.
// - Run bit self-clears when generation finishes.
// - Burst stop waits for current cycle end.
// - Continuous stop waits for zero crossing.
// - Select bit picks step words or keypad.
// - Four-bit key code, E star, F hash.
// - Control: run 7, select 4, code 3:0.
// - Output select: sum, first, second, raised cosine.
// - Repeat code gives 1..32 or endless.
// - On time 10 ms, then 50 ms steps.
// - Off time uses the same scale.
package dtg_pkg;
   // Clock, millisecond and sample timing.
   localparam int CLK_HZ        = 25_000_000;
   localparam int MS_UNIT       = 1;
   localparam int MS_CYCLES     = CLK_HZ / 1000 * MS_UNIT;
   localparam int SAMPLE_HZ     = 12000;
   localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
   // Register indices; byte address is four times the index.
   localparam logic [9:0] IDX_CTRL = 10'h0a0;
   localparam logic [9:0] IDX_OSEL = 10'h0a1;
   localparam logic [9:0] IDX_F1L  = 10'h0a2;
   localparam logic [9:0] IDX_F1H  = 10'h0a3;
   localparam logic [9:0] IDX_F2L  = 10'h0a4;
   localparam logic [9:0] IDX_F2H  = 10'h0a5;
   localparam logic [9:0] IDX_REP  = 10'h0a6;
   localparam logic [9:0] IDX_ON   = 10'h0a7;
   localparam logic [9:0] IDX_OFF  = 10'h0a8;
   // Field positions and reset values.
   localparam int          RUN_BIT     = 7;
   localparam int          KSEL_BIT    = 4;
   localparam logic        RUN_RST     = 1'h0;
   localparam logic        KSEL_RST    = 1'h0;
   localparam logic [3:0]  CODE_RST    = 4'h0;
   localparam logic [1:0]  OSEL_RST    = 2'h0;
   localparam logic [15:0] F1_RST      = 16'h1555;
   localparam logic [15:0] F2_RST      = 16'h4000;
   localparam logic [2:0]  REP_RST     = 3'h0;
   localparam logic [5:0]  ON_RST      = 6'h02;
   localparam logic [5:0]  OFF_RST     = 6'h01;
   // Period code scale in milliseconds, code limits and the endless repeat code.
   localparam logic [10:0] SHORT_STEP_MS = 11'h00a;
   localparam logic [10:0] LONG_STEP_MS  = 11'h032;
   localparam logic [10:0] LONG_BASE_MS  = 11'h0fa;
   localparam logic [5:0]  SHORT_MAX     = 6'h14;
   localparam logic [5:0]  LONG_FIRST    = 6'h19;
   localparam logic [5:0]  LONG_LAST     = 6'h3c;
   localparam logic [5:0]  CONT_CODE     = 6'h3f;
   localparam logic [2:0]  REP_INF       = 3'h7;
   // Output selections, special keys and waveform constants.
   localparam logic [1:0]  OSEL_SUM  = 2'h0;
   localparam logic [1:0]  OSEL_ONE  = 2'h1;
   localparam logic [1:0]  OSEL_TWO  = 2'h2;
   localparam logic [3:0]  KEY_STAR  = 4'he;
   localparam logic [3:0]  KEY_HASH  = 4'hf;
   localparam logic [15:0] SINE_PEAK = 16'h2000;
   localparam logic [15:0] QUARTER   = 16'h4000;
   // Step words of the low and high signalling groups at 12 kHz.
   localparam logic [15:0] ROW_STEP [4] = '{16'h0edd, 16'h106c, 16'h122c, 16'h1412};
   localparam logic [15:0] COL_STEP [4] = '{16'h19c9, 16'h1c7f, 16'h1f81, 16'h22d5};
   typedef enum logic [1:0] {DTG_IDLE, DTG_ON, DTG_OFF} dtg_state_e;
endpackage

// *** verilog/dtg_top.sv ***
// Keypad tone generator: Wishbone registers, burst engine and sample FIFO.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module dtg_fifo #(
   parameter int W = 16,
   parameter int D = 16
) (
   // Clock and reset.
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Filling side.
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   // Draining side.
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(D);
   localparam int CW = $clog2(D + 1);
   logic [W-1:0]  mem_reg [D];
   logic [W-1:0]  mem_next [D];
   logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic          push, pop;

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      nxt = (p == AW'(D - 1)) ? '0 : p + 1'b1;
   endfunction

   // Full and empty come from the count, so both stay honest.
   always_comb begin
      in_ready_o  = (cnt_reg != CW'(D));
      out_valid_o = (cnt_reg != '0);
      out_data_o  = mem_reg[rd_reg];
      push        = in_valid_i & in_ready_o;
      pop         = out_valid_o & out_ready_i;
      mem_next    = mem_reg;
      wr_next     = wr_reg;
      rd_next     = rd_reg;
      cnt_next    = cnt_reg;
      if (push) begin
         mem_next[wr_reg] = in_data_i;
         wr_next          = nxt(wr_reg);
      end
      if (pop) begin
         rd_next = nxt(rd_reg);
      end
      if (push & ~pop) begin
         cnt_next = cnt_reg + 1'b1;
      end else if (pop & ~push) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   // Storage needs no reset; only the pointers and the count do.
   always_ff @(posedge clk_i) begin
      mem_reg <= mem_next;
      if (rst_i) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule // dtg_fifo

module dtg_top #(
   parameter int MS_CYC   = dtg_pkg::MS_CYCLES,
   parameter int SAMP_DIV = dtg_pkg::SAMPLE_CYCLES,
   parameter int FIFO_D   = 16
) (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave.
   input  wire logic [11:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Tone sample stream.
   output logic [15:0]      tone_data_o,
   output logic             tone_valid_o,
   input  wire logic        tone_ready_i
);
   localparam int MSW = $clog2(MS_CYC);
   localparam int SPW = $clog2(SAMP_DIV);
   dtg_pkg::dtg_state_e st_reg, st_next;
   logic        ack_reg, ack_next, run_reg, run_next, ksel_reg, ksel_next;
   logic [31:0] rd_reg, rd_next;
   logic [3:0]  code_reg, code_next, rc;
   logic [1:0]  osel_reg, osel_next;
   logic [15:0] f1_reg, f1_next, f2_reg, f2_next, ph1_reg, ph1_next, ph2_reg, ph2_next;
   logic [2:0]  rep_reg, rep_next;
   logic [5:0]  on_reg, on_next, off_reg, off_next, left_reg, left_next;
   logic [10:0] msl_reg, msl_next;
   logic [MSW-1:0] msc_reg, msc_next;
   logic [SPW-1:0] spc_reg, spc_next;
   logic        want_reg, want_next, sign_reg, sign_next;
   logic        ov_reg, ov_next;
   logic [15:0] od_reg, od_next;
   logic [15:0] samp, mix, step1, step2, fifo_od;
   logic [9:0]  idx;
   logic        acc, wr, wr_ctrl, ms_tick, push, zc, last, fifo_ir, fifo_ov, pop;

   // Parabolic half-wave sine; cheap and smooth enough for beeps.
   function automatic logic [15:0] sine(input logic [15:0] ph);
      logic [29:0] p;
      p    = {15'h0, ph[14:0]} * {15'h0, 15'h7fff - ph[14:0]};
      sine = ph[15] ? 16'h0 - {1'b0, p[29:15]} : {1'b0, p[29:15]};
   endfunction

   // Period code to milliseconds; reserved codes clamp to a neighbour.
   function automatic logic [10:0] per_ms(input logic [5:0] c);
      logic [5:0] k;
      k = (c > dtg_pkg::LONG_LAST) ? dtg_pkg::LONG_LAST : c;
      if (k <= dtg_pkg::SHORT_MAX) begin
         per_ms = 11'(k) * dtg_pkg::SHORT_STEP_MS;
      end else if (k < dtg_pkg::LONG_FIRST) begin
         per_ms = 11'(dtg_pkg::SHORT_MAX) * dtg_pkg::SHORT_STEP_MS;
      end else begin
         per_ms = dtg_pkg::LONG_BASE_MS + 11'(k - dtg_pkg::LONG_FIRST) * dtg_pkg::LONG_STEP_MS;
      end
   endfunction

   // Repeat code to burst count; code 7 stands for endless and gives zero.
   function automatic logic [5:0] reps(input logic [2:0] r);
      unique case (r)
         3'h4: reps = 6'h08;
         3'h5: reps = 6'h10;
         3'h6: reps = 6'h20;
         3'h7: reps = 6'h00;
         default: reps = {3'h0, r} + 6'h01;
      endcase
   endfunction

   // Key code to row and column index of the keypad grid.
   always_comb begin
      unique case (code_reg)
         4'h1: rc = 4'h0;
         4'h2: rc = 4'h1;
         4'h3: rc = 4'h2;
         4'ha: rc = 4'h3;
         4'h4: rc = 4'h4;
         4'h5: rc = 4'h5;
         4'h6: rc = 4'h6;
         4'hb: rc = 4'h7;
         4'h7: rc = 4'h8;
         4'h8: rc = 4'h9;
         4'h9: rc = 4'ha;
         4'hc: rc = 4'hb;
         dtg_pkg::KEY_STAR: rc = 4'hc;
         4'h0: rc = 4'hd;
         dtg_pkg::KEY_HASH: rc = 4'he;
         4'hd: rc = 4'hf;
      endcase
   end

   // Step and sample selection; key mode always sums its pair.
   always_comb begin
      step1 = ksel_reg ? dtg_pkg::ROW_STEP[rc[3:2]] : f1_reg;
      step2 = ksel_reg ? dtg_pkg::COL_STEP[rc[1:0]] : f2_reg;
      unique case (osel_reg)
         dtg_pkg::OSEL_SUM: mix = sine(ph1_reg) + sine(ph2_reg);
         dtg_pkg::OSEL_ONE: mix = sine(ph1_reg);
         dtg_pkg::OSEL_TWO: mix = sine(ph2_reg);
         default: mix = dtg_pkg::SINE_PEAK - sine(ph1_reg + dtg_pkg::QUARTER);
      endcase
      if (ksel_reg) begin
         mix = sine(ph1_reg) + sine(ph2_reg);
      end
      samp = (st_reg == dtg_pkg::DTG_ON) ? mix : 16'h0;
   end

   // Register file; a write lands at the edge where the master samples ack.
   always_comb begin
      idx       = wb_adr_i[11:2];
      acc       = wb_cyc_i & wb_stb_i & ~ack_reg;
      wr        = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i & wb_sel_i[0];
      wr_ctrl   = wr & (idx == dtg_pkg::IDX_CTRL);
      ack_next  = acc;
      rd_next   = rd_reg;
      ksel_next = ksel_reg;
      code_next = code_reg;
      osel_next = osel_reg;
      f1_next   = f1_reg;
      f2_next   = f2_reg;
      rep_next  = rep_reg;
      on_next   = on_reg;
      off_next  = off_reg;
      if (wr) begin
         unique case (idx)
            dtg_pkg::IDX_CTRL: begin
               ksel_next = wb_dat_i[dtg_pkg::KSEL_BIT];
               code_next = wb_dat_i[3:0];
            end
            dtg_pkg::IDX_OSEL: osel_next = wb_dat_i[1:0];
            dtg_pkg::IDX_F1L: f1_next[7:0] = wb_dat_i[7:0];
            dtg_pkg::IDX_F1H: f1_next[15:8] = wb_dat_i[7:0];
            dtg_pkg::IDX_F2L: f2_next[7:0] = wb_dat_i[7:0];
            dtg_pkg::IDX_F2H: f2_next[15:8] = wb_dat_i[7:0];
            dtg_pkg::IDX_REP: rep_next = wb_dat_i[2:0];
            dtg_pkg::IDX_ON: on_next = wb_dat_i[5:0];
            dtg_pkg::IDX_OFF: off_next = wb_dat_i[5:0];
            default: ;
         endcase
      end
      if (acc) begin
         unique case (idx)
            dtg_pkg::IDX_CTRL: rd_next = {24'h0, run_reg, 2'h0, ksel_reg, code_reg};
            dtg_pkg::IDX_OSEL: rd_next = {30'h0, osel_reg};
            dtg_pkg::IDX_F1L: rd_next = {24'h0, f1_reg[7:0]};
            dtg_pkg::IDX_F1H: rd_next = {24'h0, f1_reg[15:8]};
            dtg_pkg::IDX_F2L: rd_next = {24'h0, f2_reg[7:0]};
            dtg_pkg::IDX_F2H: rd_next = {24'h0, f2_reg[15:8]};
            dtg_pkg::IDX_REP: rd_next = {29'h0, rep_reg};
            dtg_pkg::IDX_ON: rd_next = {26'h0, on_reg};
            dtg_pkg::IDX_OFF: rd_next = {26'h0, off_reg};
            default: rd_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg  <= 1'h0;
         rd_reg   <= 32'h0;
         ksel_reg <= dtg_pkg::KSEL_RST;
         code_reg <= dtg_pkg::CODE_RST;
         osel_reg <= dtg_pkg::OSEL_RST;
         f1_reg   <= dtg_pkg::F1_RST;
         f2_reg   <= dtg_pkg::F2_RST;
         rep_reg  <= dtg_pkg::REP_RST;
         on_reg   <= dtg_pkg::ON_RST;
         off_reg  <= dtg_pkg::OFF_RST;
      end else begin
         ack_reg  <= ack_next;
         rd_reg   <= rd_next;
         ksel_reg <= ksel_next;
         code_reg <= code_next;
         osel_reg <= osel_next;
         f1_reg   <= f1_next;
         f2_reg   <= f2_next;
         rep_reg  <= rep_next;
         on_reg   <= on_next;
         off_reg  <= off_next;
      end
   end

   // Burst engine. Phases only move when a sample enters the FIFO, so a
   // stalled stream slows the tone instead of tearing it.
   always_comb begin
      st_next   = st_reg;
      run_next  = run_reg;
      left_next = left_reg;
      msl_next  = msl_reg;
      ph1_next  = ph1_reg;
      ph2_next  = ph2_reg;
      sign_next = sign_reg;
      want_next = want_reg;
      push      = want_reg & fifo_ir;
      zc        = push & ((samp == 16'h0) | (samp[15] != sign_reg));
      ms_tick   = (msc_reg == MSW'(MS_CYC - 1));
      msc_next  = ms_tick ? '0 : msc_reg + 1'b1;
      spc_next  = spc_reg + 1'b1;
      last      = ~run_reg | ((rep_reg != dtg_pkg::REP_INF) & (left_reg <= 6'h01));
      if (push) begin
         want_next = 1'b0;
         sign_next = samp[15];
         if (st_reg == dtg_pkg::DTG_ON) begin
            ph1_next = ph1_reg + step1 + 16'h1;
            ph2_next = ph2_reg + step2 + 16'h1;
         end
      end
      if (spc_reg == SPW'(SAMP_DIV - 1)) begin
         spc_next  = '0;
         want_next = 1'b1;
      end
      if (ms_tick & (msl_reg != 11'h0)) begin
         msl_next = msl_reg - 11'h1;
      end
      unique case (st_reg)
         dtg_pkg::DTG_IDLE: begin
            if (run_reg) begin
               st_next   = dtg_pkg::DTG_ON;
               left_next = reps(rep_reg);
               msl_next  = per_ms(on_reg);
               msc_next  = '0;
               ph1_next  = 16'h0;
               ph2_next  = 16'h0;
            end
         end
         dtg_pkg::DTG_ON: begin
            if (on_reg == dtg_pkg::CONT_CODE) begin
               if (~run_reg & zc) begin
                  st_next = dtg_pkg::DTG_IDLE;
               end
            end else if (ms_tick & (msl_reg <= 11'h1)) begin
               st_next  = dtg_pkg::DTG_OFF;
               msl_next = per_ms(off_reg);
               msc_next = '0;
            end
         end
         dtg_pkg::DTG_OFF: begin
            if (ms_tick & (msl_reg <= 11'h1)) begin
               if (last) begin
                  st_next = dtg_pkg::DTG_IDLE;
               end else begin
                  st_next   = dtg_pkg::DTG_ON;
                  left_next = left_reg - 6'h1;
                  msl_next  = per_ms(on_reg);
                  msc_next  = '0;
                  ph1_next  = 16'h0;
                  ph2_next  = 16'h0;
               end
            end
         end
      endcase
      if ((st_reg != dtg_pkg::DTG_IDLE) & (st_next == dtg_pkg::DTG_IDLE)) begin
         run_next = 1'b0;
      end
      // A software write comes last, so a set in the finishing cycle wins.
      if (wr_ctrl) begin
         run_next = wb_dat_i[dtg_pkg::RUN_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg   <= dtg_pkg::DTG_IDLE;
         run_reg  <= dtg_pkg::RUN_RST;
         left_reg <= 6'h0;
         msl_reg  <= 11'h0;
         msc_reg  <= '0;
         spc_reg  <= '0;
         ph1_reg  <= 16'h0;
         ph2_reg  <= 16'h0;
         sign_reg <= 1'h0;
         want_reg <= 1'h0;
      end else begin
         st_reg   <= st_next;
         run_reg  <= run_next;
         left_reg <= left_next;
         msl_reg  <= msl_next;
         msc_reg  <= msc_next;
         spc_reg  <= spc_next;
         ph1_reg  <= ph1_next;
         ph2_reg  <= ph2_next;
         sign_reg <= sign_next;
         want_reg <= want_next;
      end
   end

   dtg_fifo #(.W(16), .D(FIFO_D)) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (want_reg),
      .in_data_i   (samp),
      .in_ready_o  (fifo_ir),
      .out_valid_o (fifo_ov),
      .out_data_o  (fifo_od),
      .out_ready_i (pop)
   );

   // Output register keeps every top output on a flip-flop.
   always_comb begin
      pop     = fifo_ov & (~ov_reg | tone_ready_i);
      ov_next = pop | (ov_reg & ~tone_ready_i);
      od_next = pop ? fifo_od : od_reg;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ov_reg <= 1'h0;
         od_reg <= 16'h0;
      end else begin
         ov_reg <= ov_next;
         od_reg <= od_next;
      end
   end

   assign wb_ack_o     = ack_reg;
   assign wb_dat_o     = rd_reg;
   assign tone_valid_o = ov_reg;
   assign tone_data_o  = od_reg;

   // Checks on the engine and the bus.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
   a_run_start: assert property (wr_ctrl && wb_dat_i[7] && st_reg == dtg_pkg::DTG_IDLE
      |=> run_reg ##1 st_reg == dtg_pkg::DTG_ON) else $error("start not taken");
   a_run_clear: assert property (st_reg == dtg_pkg::DTG_OFF && st_next == dtg_pkg::DTG_IDLE
      && !wr_ctrl |=> !run_reg) else $error("run bit not cleared");
   a_burst_stop: assert property (st_reg == dtg_pkg::DTG_ON && on_reg != 6'h3f
      |=> st_reg != dtg_pkg::DTG_IDLE) else $error("burst cut short");
   a_cont_stop: assert property (st_reg == dtg_pkg::DTG_ON && on_reg == 6'h3f && !push
      |=> st_reg == dtg_pkg::DTG_ON) else $error("stop off zero crossing");
   a_key_one: assert property (push && st_reg == dtg_pkg::DTG_ON && ksel_reg
      && code_reg == 4'h1 |=> ph1_reg == $past(ph1_reg) + 16'h0ede) else $error("key 1 row step");
   a_key_star: assert property (push && st_reg == dtg_pkg::DTG_ON && ksel_reg
      && code_reg == 4'he |=> ph2_reg == $past(ph2_reg) + 16'h19ca) else $error("star col step");
   a_ctrl_fields: assert property (wr_ctrl |=> ksel_reg == $past(wb_dat_i[4])
      && code_reg == $past(wb_dat_i[3:0])) else $error("control fields");
   a_sel_second: assert property (st_reg == dtg_pkg::DTG_ON && !ksel_reg && osel_reg == 2'h2
      |-> samp == sine(ph2_reg)) else $error("second only select");
   a_burst_more: assert property (st_reg == dtg_pkg::DTG_OFF && st_next == dtg_pkg::DTG_ON
      |-> run_reg && (rep_reg == 3'h7 || left_reg > 6'h1)) else $error("extra burst");
   a_on_long: assert property (st_reg == dtg_pkg::DTG_IDLE && run_reg && on_reg == 6'h19
      |=> msl_reg == 11'h0fa) else $error("on time 250 ms");
   a_off_short: assert property (st_reg == dtg_pkg::DTG_ON && st_next == dtg_pkg::DTG_OFF
      && off_reg == 6'h14 |=> msl_reg == 11'h0c8) else $error("off time 200 ms");
   c_rebursts: cover property (st_reg == dtg_pkg::DTG_OFF ##1 st_reg == dtg_pkg::DTG_ON);
   c_key_tone: cover property (ksel_reg && push && st_reg == dtg_pkg::DTG_ON);
   c_cont_stop: cover property (on_reg == 6'h3f && st_reg == dtg_pkg::DTG_ON
      ##1 st_reg == dtg_pkg::DTG_IDLE);
   c_fifo_full: cover property (!fifo_ir);
endmodule // dtg_top

// *** dv/dtg_top_tb.sv ***
// Self-checking bench for the keypad tone generator.
`timescale 1ns/1ps
module dtg_top_tb;
   localparam int MS = 2;
   // Bus, stream and bench state.
   logic        clk_i, wb_ack_o, tone_valid_o, pv, pt;
   logic        rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic        tone_ready_i = 1'b1, stall = 1'b0, rnd_rdy = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [15:0] tone_data_o, pd, v, a [8], b [8], c [8];
   logic [15:0] smp [$];
   logic [7:0]  mdl [9] = '{8'h00, 8'h00, 8'h55, 8'h15, 8'h00, 8'h40, 8'h00, 8'h02, 8'h01};
   logic [7:0]  msk [9] = '{8'h1f, 8'h03, 8'hff, 8'hff, 8'hff, 8'hff, 8'h07, 8'h3f, 8'h3f};
   // Row and column of each key code, packed as {row, column}.
   logic [3:0]  rc [16] = '{4'hd, 4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8,
                            4'h9, 4'ha, 4'h3, 4'h7, 4'hb, 4'hf, 4'hc, 4'he};
   int          nb [7] = '{1, 2, 3, 4, 8, 16, 32};
   integer      failures = 0, n_tests = 0, seed = 32'he8fca6a1, cyc_n = 0;
   integer      i, j, k, e, t0, t1;

   dtg_top #(.MS_CYC(MS), .SAMP_DIV(4), .FIFO_D(16)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tone_data_o(tone_data_o),
      .tone_valid_o(tone_valid_o), .tone_ready_i(tone_ready_i));

   // Free-running 25 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // Sink: random or stalled ready; a sample not taken must stay put.
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      tone_ready_i <= stall ? 1'b0 : (rnd_rdy ? (($random(seed) & 1) != 0) : 1'b1);
      if (!rst_i && pv && !pt) chk(32'({tone_valid_o, tone_data_o}), 32'({1'b1, pd}));
      pv <= tone_valid_o;
      pd <= tone_data_o;
      pt <= tone_ready_i;
      if (tone_valid_o && tone_ready_i) smp.push_back(tone_data_o);
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("Error at %0t ns: saw %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("Totals: %0d comparisons, %0d mismatches", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One classic cycle; the low address bits and upper data are random filler.
   task automatic wb(input logic we, input logic [9:0] idx, input logic [7:0] d,
                     input logic [3:0] sel);
      int n;
      logic [31:0] r;
      r = $random(seed);
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, r[1:0]};
      wb_dat_i <= {r[31:8], d};
      wb_sel_i <= sel;
      do begin
         @(posedge clk_i);
         n = n + 1;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         failures = failures + 1;
         complete_run();
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   // Write that also updates the bench's register model.
   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [9:0] m;
      m = idx - dtg_pkg::IDX_CTRL;
      wb(1'b1, idx, d, 4'hf);
      if (m < 10'd9) mdl[m] = d & msk[m];
   endtask

   task automatic rd(input logic [9:0] idx);
      logic [9:0] m;
      m = idx - dtg_pkg::IDX_CTRL;
      wb(1'b0, idx, 8'h00, 4'hf);
      chk(q, (m < 10'd9) ? {24'h0, mdl[m]} : 32'h0);
   endtask

   task automatic step(input logic [9:0] idx, input logic [15:0] w);
      wr(idx, w[7:0]);
      wr(idx + 10'h001, w[15:8]);
   endtask

   // Polls the run bit until it clears; t1 marks the moment.
   task automatic idle(input int lim);
      int n;
      n = 0;
      do begin
         wb(1'b0, dtg_pkg::IDX_CTRL, 8'h00, 4'hf);
         n = n + 1;
      end while (q[7] !== 1'b0 && n < lim);
      t1 = cyc_n;
      if (n >= lim) begin
         failures = failures + 1;
         complete_run();
      end
   endtask

   function automatic int per(input logic [7:0] cd);
      return (cd <= 8'h14) ? int'(cd) * 10 : 250 + (int'(cd) - 25) * 50;
   endfunction

   // One burst; keeps 8 samples from the first non-zero one, stalling the sink for 120 cycles when st is set.
   task automatic cap(input logic [7:0] ctl, input logic st, output logic [15:0] s [8]);
      int f, n;
      f = 0;
      n = 0;
      smp.delete();
      wr(dtg_pkg::IDX_CTRL, ctl | 8'h80);
      do begin
         @(posedge clk_i);
         n = n + 1;
         while (f < smp.size() && smp[f] === 16'h0000) f = f + 1;
      end while (f >= smp.size() && n < 3000);
      stall <= st;
      repeat (120) @(posedge clk_i);
      stall <= 1'b0;
      idle(500);
      if (smp.size() < f + 8) begin
         failures = failures + 1;
         complete_run();
      end
      for (n = 0; n < 8; n++) s[n] = smp[f + n];
   endtask

   // Hang guard.
   initial begin
      repeat (90000) @(posedge clk_i);
      failures = failures + 1;
      complete_run();
   end

   // Main sequence.
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 10; i++) rd(dtg_pkg::IDX_CTRL + 10'(i));
      $display("Reset value test done");
      for (i = 0; i < 27; i++) begin
         v = 16'($random(seed));
         j = i % 9;
         wr(dtg_pkg::IDX_CTRL + 10'(j), (j == 0) ? (v[7:0] & 8'h7f) : v[7:0]);
         rd(dtg_pkg::IDX_CTRL + 10'(j));
      end
      wb(1'b1, dtg_pkg::IDX_F1L, ~mdl[2], 4'he);
      rd(dtg_pkg::IDX_F1L);
      wb(1'b1, 10'h0b0, 8'hff, 4'hf);
      rd(10'h0b0);
      $display("Register access test done");
      for (i = 0; i < 9; i++) begin
         wr(dtg_pkg::IDX_REP, (i < 7) ? 8'(i) : 8'h00);
         wr(dtg_pkg::IDX_ON, (i < 7) ? 8'h01 : ((i == 7) ? 8'h19 : 8'h3c));
         wr(dtg_pkg::IDX_OFF, (i == 7) ? 8'h14 : 8'h01);
         k = (i < 7) ? nb[i] : 1;
         e = k * (per(mdl[7]) + per(mdl[8])) * MS;
         wr(dtg_pkg::IDX_CTRL, 8'h80);
         t0 = cyc_n;
         wb(1'b0, dtg_pkg::IDX_CTRL, 8'h00, 4'hf);
         chk(32'(q[7]), 32'h1);
         idle(4000);
         chk(32'(t1 - t0 > e - k * 8 * MS && t1 - t0 < e + k * 8 * MS + 40), 32'h1);
      end
      $display("Burst timing test done");
      wr(dtg_pkg::IDX_REP, 8'h07);
      wr(dtg_pkg::IDX_ON, 8'h0a);
      wr(dtg_pkg::IDX_OFF, 8'h0a);
      wr(dtg_pkg::IDX_OSEL, 8'h03);
      wr(dtg_pkg::IDX_CTRL, 8'h80);
      repeat (900) @(posedge clk_i);
      wr(dtg_pkg::IDX_CTRL, 8'h00);
      smp.delete();
      repeat (60) @(posedge clk_i);
      e = 0;
      for (k = 0; k < smp.size(); k++) if (smp[k] !== 16'h0) e = 1;
      chk(32'(e), 32'h1);
      repeat (200) @(posedge clk_i);
      smp.delete();
      repeat (400) @(posedge clk_i);
      for (k = 0; k < smp.size(); k++) chk(32'(smp[k]), 32'h0);
      $display("Graceful stop test done");
      wr(dtg_pkg::IDX_OSEL, 8'h01);
      wr(dtg_pkg::IDX_ON, 8'h3f);
      wr(dtg_pkg::IDX_REP, 8'h00);
      step(dtg_pkg::IDX_F1L, 16'h0fff);
      wr(dtg_pkg::IDX_CTRL, 8'h80);
      repeat (8800) @(posedge clk_i);
      wb(1'b0, dtg_pkg::IDX_CTRL, 8'h00, 4'hf);
      chk(32'(q[7]), 32'h1);
      wr(dtg_pkg::IDX_CTRL, 8'h00);
      t0 = cyc_n;
      idle(100);
      chk(32'(t1 - t0 < 120), 32'h1);
      repeat (100) @(posedge clk_i);
      smp.delete();
      repeat (60) @(posedge clk_i);
      for (k = 0; k < smp.size(); k++) chk(32'(smp[k]), 32'h0);
      $display("Continuous stop test done");
      rnd_rdy <= 1'b1;
      wr(dtg_pkg::IDX_ON, 8'h0a);
      wr(dtg_pkg::IDX_OFF, 8'h01);
      v = 16'($random(seed));
      step(dtg_pkg::IDX_F1L, {4'h0, v[11:0]} + 16'h0400);
      step(dtg_pkg::IDX_F2L, {4'h0, v[15:4]} + 16'h0400);
      wr(dtg_pkg::IDX_OSEL, 8'h01);
      cap(8'h00, 1'b1, a);
      wr(dtg_pkg::IDX_OSEL, 8'h02);
      cap(8'h00, 1'b0, b);
      wr(dtg_pkg::IDX_OSEL, 8'h00);
      cap(8'h00, 1'b1, c);
      for (k = 0; k < 8; k++) chk(32'(c[k]), 32'(16'(a[k] + b[k])));
      wr(dtg_pkg::IDX_OSEL, 8'h03);
      cap(8'h00, 1'b0, a);
      for (k = 0; k < 8; k++) chk(32'($signed(a[k]) >= 0), 32'h1);
      $display("Output select test done");
      for (i = 0; i < 16; i++) begin
         step(dtg_pkg::IDX_F1L, dtg_pkg::ROW_STEP[rc[i][3:2]]);
         step(dtg_pkg::IDX_F2L, dtg_pkg::COL_STEP[rc[i][1:0]]);
         wr(dtg_pkg::IDX_OSEL, 8'h00);
         cap(8'h00, i[0], a);
         wr(dtg_pkg::IDX_OSEL, 8'h02);
         cap(8'h10 | 8'(i), ~i[0], b);
         for (k = 0; k < 8; k++) chk(32'(b[k]), 32'(a[k]));
         rd(dtg_pkg::IDX_CTRL);
      end
      $display("Keypad tone test done");
      complete_run();
   end
endmodule // dtg_top_tb
